// [core/vsp_clk_div.sv]
/*
 Serial clock divider: makes the serial clock level and one-cycle pulses
 on its rising and falling edges from the system clock.
 Assumes the caller holds i_run low while the port is deselected.
*/
`timescale 1ns/1ps
module vsp_clk_div
(
   // Clock and reset.
   input  wire logic I_CLK,
   input  wire logic I_RSTN,
   // Run enable.
   input  wire logic i_run,
   // Serial clock and edges.
   output logic      o_sclk,
   output logic      o_rise,
   output logic      o_fall
);

   typedef struct packed
   {
      logic [vsp_pkg::DIV_CNT_W-1:0] cnt;
      logic                          sclk;
   } vsp_div_s;

   vsp_div_s st_q;
   vsp_div_s st_d;

   always_comb
   begin
      st_d = st_q;
      if (!i_run)
      begin
         st_d.cnt  = '0;
         st_d.sclk = 1'b0;
      end
      else if (st_q.cnt == 3'(vsp_pkg::SCLK_DIV - 1))
      begin
         st_d.cnt  = '0;
         st_d.sclk = 1'b1;
      end
      else
      begin
         st_d.cnt = st_q.cnt + 3'h1;
         // Low for three cycles and high for two keeps the period at five.
         if (st_q.cnt == 3'h1)
         begin
            st_d.sclk = 1'b0;
         end
      end
   end

   always_ff @(posedge I_CLK or negedge I_RSTN)
   begin
      if (!I_RSTN)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign o_sclk = st_q.sclk;
   assign o_rise = i_run && (st_q.cnt == 3'(vsp_pkg::SCLK_DIV - 1));
   assign o_fall = i_run && (st_q.cnt == 3'h1);

endmodule

// [core/vsp_pkg.sv]
/*
 Package for the voiceband serial control port: configuration register
 field positions, reset value, serial framing counts and state encodings.
 Assumes a 100 MHz system clock standing in for the codec master clock.
*/
package vsp_pkg;

   // Configuration register layout.
   localparam int          CFG_W           = 16;
   localparam logic [15:0] CFG_RESET       = 16'h0000;
   localparam int          CFG_PREAMP_BIT  = 0;
   localparam int          CFG_SRC_BIT     = 1;
   localparam int          CFG_OUT_HPF_BIT = 2;
   localparam int          CFG_IN_HPF_BIT  = 3;
   localparam int          CFG_APWR_BIT    = 4;
   localparam int          CFG_DPWR_BIT    = 5;
   localparam int          CFG_GAIN_LSB    = 7;
   localparam int          CFG_GAIN_W      = 3;
   localparam int          WORD_MSB        = 15;
   localparam int          WORD_MSB2       = 14;

   // Serial timing.
   localparam int          SCLK_DIV        = 5;
   localparam int          FRAME_SCLKS     = 325;
   localparam int          STARTUP_SCLKS   = 64;
   localparam int          BIT_CNT_W       = 5;
   localparam int          DIV_CNT_W       = 3;
   localparam int          FRAME_CNT_W     = 9;
   localparam logic [4:0]  WORD_BITS       = 5'h10;

   // Transmit sequencer states.
   typedef enum logic [1:0]
   {
      TX_OFF   = 2'b00,
      TX_START = 2'b01,
      TX_RUN   = 2'b10,
      TX_HOLD  = 2'b11
   } vsp_tx_e;

endpackage

// [core/vsp_port.sv]
/*
 Serial port and configuration register of a voiceband codec front end.
 Receives 16-bit words from the host, keeps the configuration register,
 answers read-back requests and sends samples at the frame rate.
 Assumes converter samples arrive on i_adc_sample and that the serial
 clock is the system clock divided by five.
*/
// Behaviour
// - Send samples only when both power bits set.
// - Wait a start-up interval after leaving powerdown.
// - One 16-bit word each frame period.
// - Frame sync pulse, word one cycle later.
// - Input word starts cycle after input sync.
// - Sample input on falling edge, MSB first.
// - Ignore input sync until last bit's falling edge.
// - Reset clears configuration register.
// - Control word with top bit zero loads register.
// - Bit 0 inserts the input preamplifier.
// - Bit 1 selects auxiliary input.
// - Bits 2 and 3 bypass high-pass filters.
// - Bits 7 to 9 select output gain.
// - Top bit one is read request, no write.
// - Read-ready word sends register, then resumes.
// - Serial clock is master clock over five.
// - Chip select low disables and three-states port.
`timescale 1ns/1ps
module vsp_port
(
   // Clock and reset.
   input  wire logic                       I_CLK,
   input  wire logic                       I_RSTN,
   // Chip select.
   input  wire logic                       I_CHIP_SEL,
   // Host serial inputs.
   input  wire logic                       I_IN_FRAME_SYNC,
   input  wire logic                       I_SERIAL_IN_LINE,
   input  wire logic                       I_WORD_TYPE_SELECT,
   // Serial outputs with enables.
   output logic                            O_SCLK,
   output logic                            O_SCLK_OE,
   output logic                            O_OUT_FRAME_SYNC,
   output logic                            O_OUT_FRAME_SYNC_OE,
   output logic                            O_SERIAL_OUT_LINE,
   output logic                            O_SERIAL_OUT_LINE_OE,
   // Converter side.
   input  wire logic [15:0]                I_ADC_SAMPLE,
   output logic [15:0]                     O_DAC_SAMPLE,
   output logic                            O_DAC_STROBE,
   // Configuration fields.
   output logic                            O_PREAMP_INSERT,
   output logic                            O_INPUT_SOURCE_SEL,
   output logic                            O_OUT_HPF_BYPASS,
   output logic                            O_IN_HPF_BYPASS,
   output logic                            O_ANALOG_POWER_ON,
   output logic                            O_DIGITAL_POWER_ON,
   output logic [2:0]                      O_OUTPUT_GAIN_CODE,
   output logic [15:0]                     O_CODEC_CONFIGURATION
);

   typedef struct packed
   {
      logic [15:0]                          cfg;
      logic                                 rx_busy;
      logic                                 rx_armed;
      logic                                 rx_data;
      logic [vsp_pkg::BIT_CNT_W-1:0]        rx_cnt;
      logic [15:0]                          rx_sh;
      logic                                 rd_pend;
      logic                                 rd_go;
      vsp_pkg::vsp_tx_e                     tx_st;
      logic [vsp_pkg::FRAME_CNT_W-1:0]      frm_cnt;
      logic                                 tx_busy;
      logic                                 tx_first;
      logic [vsp_pkg::BIT_CNT_W-1:0]        tx_cnt;
      logic [15:0]                          tx_sh;
      logic                                 ofs;
      logic                                 serial_out_line;
      logic [15:0]                          dac;
      logic                                 dac_stb;
   } vsp_port_s;

   vsp_port_s st_q;
   vsp_port_s st_d;

   logic sclk;
   logic rise;
   logic fall;
   logic run_rstn;
   logic powered;
   logic word_done;

   // The divider is parked through its run input while deselected, so the clock stays low.
   assign run_rstn = I_RSTN;

   vsp_clk_div u_div
   (
      .I_CLK  (I_CLK),
      .I_RSTN (run_rstn),
      .i_run  (I_CHIP_SEL),
      .o_sclk (sclk),
      .o_rise (rise),
      .o_fall (fall)
   );

   assign powered   = st_q.cfg[vsp_pkg::CFG_APWR_BIT] && st_q.cfg[vsp_pkg::CFG_DPWR_BIT];
   assign word_done = st_q.rx_busy && fall && (st_q.rx_cnt == 5'h01);

   always_comb
   begin
      st_d         = st_q;
      st_d.dac_stb = 1'b0;
      if (!I_CHIP_SEL)
      begin
         // Deselect abandons a word being received or shifted out; the register keeps its value.
         st_d.rx_busy  = 1'b0;
         st_d.rx_armed = 1'b0;
         st_d.tx_busy  = 1'b0;
         st_d.ofs      = 1'b0;
      end
      else
      begin
         // Input sync sampled at the falling edge of its own cycle.
         if (fall && I_IN_FRAME_SYNC && (!st_q.rx_busy || word_done))
         begin
            st_d.rx_armed = 1'b1;
            st_d.rx_data  = I_WORD_TYPE_SELECT;
         end
         if (rise && st_q.rx_armed)
         begin
            st_d.rx_armed = 1'b0;
            st_d.rx_busy  = 1'b1;
            st_d.rx_cnt   = vsp_pkg::WORD_BITS;
         end
         if (st_q.rx_busy && fall)
         begin
            st_d.rx_sh  = {st_q.rx_sh[14:0], I_SERIAL_IN_LINE};
            st_d.rx_cnt = st_q.rx_cnt - 5'h01;
            if (st_q.rx_cnt == 5'h01)
            begin
               st_d.rx_busy = 1'b0;
               if (st_q.rx_data)
               begin
                  st_d.dac     = {st_q.rx_sh[14:0], I_SERIAL_IN_LINE};
                  st_d.dac_stb = 1'b1;
               end
               else if (!st_q.rx_sh[vsp_pkg::WORD_MSB - 1])
               begin
                  // Reserved bits are stored as sent; the host keeps them zero.
                  st_d.cfg = {st_q.rx_sh[14:0], I_SERIAL_IN_LINE};
               end
               else if (st_q.rx_sh[vsp_pkg::WORD_MSB2 - 1])
               begin
                  st_d.rd_go   = st_q.rd_pend;
                  st_d.rd_pend = 1'b0;
               end
               else
               begin
                  st_d.rd_pend = 1'b1;
               end
            end
         end

         // Transmit frame sequencer, stepped on serial clock rising edges.
         if (rise)
         begin
            st_d.ofs = 1'b0;
            if (st_q.frm_cnt != '0)
            begin
               st_d.frm_cnt = st_q.frm_cnt - 9'h001;
            end
            case (st_q.tx_st)
               vsp_pkg::TX_OFF:
               begin
                  if (powered)
                  begin
                     st_d.tx_st   = vsp_pkg::TX_START;
                     st_d.frm_cnt = 9'(vsp_pkg::STARTUP_SCLKS);
                  end
               end
               vsp_pkg::TX_START, vsp_pkg::TX_RUN:
               begin
                  if (!powered)
                  begin
                     st_d.tx_st = vsp_pkg::TX_OFF;
                  end
                  else if (st_q.rd_pend && !st_q.tx_busy)
                  begin
                     st_d.tx_st = vsp_pkg::TX_HOLD;
                  end
                  else if (st_q.frm_cnt == '0 || st_q.frm_cnt == 9'h001)
                  begin
                     // One word per 325 serial clocks, which is 125 us at 2.6 MHz.
                     st_d.tx_st    = vsp_pkg::TX_RUN;
                     st_d.frm_cnt  = 9'(vsp_pkg::FRAME_SCLKS);
                     st_d.ofs      = 1'b1;
                     st_d.tx_first = 1'b1;
                     st_d.tx_sh    = I_ADC_SAMPLE;
                  end
               end
               vsp_pkg::TX_HOLD:
               begin
                  if (st_q.rd_go)
                  begin
                     // Register goes out next, then the frame cadence restarts.
                     st_d.rd_go    = 1'b0;
                     st_d.tx_st    = vsp_pkg::TX_RUN;
                     st_d.frm_cnt  = 9'(vsp_pkg::FRAME_SCLKS);
                     st_d.ofs      = 1'b1;
                     st_d.tx_first = 1'b1;
                     st_d.tx_sh    = st_q.cfg;
                  end
               end
               default:
               begin
                  st_d.tx_st = vsp_pkg::TX_OFF;
               end
            endcase
            if (st_q.tx_first)
            begin
               // Shifting starts one serial clock after the sync pulse.
               st_d.tx_first = 1'b0;
               st_d.tx_busy  = 1'b1;
               st_d.tx_cnt   = vsp_pkg::WORD_BITS - 5'h01;
               st_d.serial_out_line      = st_q.tx_sh[vsp_pkg::WORD_MSB];
               st_d.tx_sh    = {st_q.tx_sh[14:0], 1'b0};
            end
            else if (st_q.tx_busy)
            begin
               if (st_q.tx_cnt == '0)
               begin
                  st_d.tx_busy = 1'b0;
               end
               else
               begin
                  st_d.tx_cnt = st_q.tx_cnt - 5'h01;
                  st_d.serial_out_line    = st_q.tx_sh[vsp_pkg::WORD_MSB];
                  st_d.tx_sh  = {st_q.tx_sh[14:0], 1'b0};
               end
            end
         end
      end
   end

   always_ff @(posedge I_CLK or negedge I_RSTN)
   begin
      if (!I_RSTN)
      begin
         st_q     <= '0;
         st_q.cfg <= vsp_pkg::CFG_RESET;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // Output enables follow chip select.
   assign O_SCLK                = sclk;
   assign O_SCLK_OE             = I_CHIP_SEL;
   assign O_OUT_FRAME_SYNC      = st_q.ofs;
   assign O_OUT_FRAME_SYNC_OE   = I_CHIP_SEL;
   assign O_SERIAL_OUT_LINE     = st_q.serial_out_line;
   assign O_SERIAL_OUT_LINE_OE  = I_CHIP_SEL;
   assign O_DAC_SAMPLE          = st_q.dac;
   assign O_DAC_STROBE          = st_q.dac_stb;
   assign O_PREAMP_INSERT       = st_q.cfg[vsp_pkg::CFG_PREAMP_BIT];
   assign O_INPUT_SOURCE_SEL    = st_q.cfg[vsp_pkg::CFG_SRC_BIT];
   assign O_OUT_HPF_BYPASS      = st_q.cfg[vsp_pkg::CFG_OUT_HPF_BIT];
   assign O_IN_HPF_BYPASS       = st_q.cfg[vsp_pkg::CFG_IN_HPF_BIT];
   assign O_ANALOG_POWER_ON     = st_q.cfg[vsp_pkg::CFG_APWR_BIT];
   assign O_DIGITAL_POWER_ON    = st_q.cfg[vsp_pkg::CFG_DPWR_BIT];
   // Code 0 is +6 dB, each step 3 dB lower.
   assign O_OUTPUT_GAIN_CODE    = st_q.cfg[vsp_pkg::CFG_GAIN_LSB +: vsp_pkg::CFG_GAIN_W];
   assign O_CODEC_CONFIGURATION = st_q.cfg;

endmodule

// [test/vsp_host.sv]
/* Host serial port model: sends framed words and collects output words.
   Assumes the serial clock stands still while the port is deselected. */
`timescale 1ns/1ps
module vsp_host
(
   // Clock.
   input  wire logic   I_CLK,
   // Serial pins.
   input  wire logic   i_sclk,
   input  wire logic   i_ofs,
   input  wire logic   i_sout,
   output logic        o_ifs,
   output logic        o_sin,
   output logic        o_wts,
   // Collected words and expired waits.
   output logic [15:0] o_rx,
   output int          o_nrx,
   output int          o_tmo
);
   logic        p_q;
   logic [15:0] sh;
   int          rc;
   initial
      {o_ifs, o_sin, o_wts, p_q, o_rx, sh, o_nrx, o_tmo, rc} = '0;
   // Output bits are taken at the clock fall, mid-way through each bit.
   always @(negedge I_CLK)
   begin
      if (p_q && !i_sclk)
      begin
         if (rc > 0)
         begin
            sh = {sh[14:0], i_sout};
            rc--;
            o_rx = (rc == 0) ? sh : o_rx;
            o_nrx += (rc == 0);
         end
         rc = i_ofs ? 16 : rc;
      end
      p_q = i_sclk;
   end
   task automatic rise();
      logic p;
      int   n;
      p = i_sclk;
      for (n = 0; n < 20; n++)
      begin
         @(negedge I_CLK);
         if (i_sclk && !p)
            return;
         p = i_sclk;
      end
      o_tmo++;
   endtask
   // A set glitch raises a stray sync in mid-word.
   task automatic send(input logic [15:0] w, input logic t, input logic g);
      int i;
      rise();
      o_ifs = 1'b1;
      o_wts = t;
      for (i = 15; i >= 0; i--)
      begin
         rise();
         o_ifs = g && (i == 7);
         o_sin = w[i];
      end
      rise();
      o_sin = ~w[0];
   endtask
endmodule

// [test/vsp_port_sva.sv]
/* Checker for the voiceband serial port, attached by the bind at the end.
   Assumes it sees only the top module's ports. */
`timescale 1ns/1ps
module vsp_port_sva
(
   // Clock, reset and select.
   input wire logic        I_CLK,
   input wire logic        I_RSTN,
   input wire logic        I_CHIP_SEL,
   // Watched outputs.
   input wire logic        O_SCLK,
   input wire logic        O_SCLK_OE,
   input wire logic        O_OUT_FRAME_SYNC,
   input wire logic        O_OUT_FRAME_SYNC_OE,
   input wire logic        O_SERIAL_OUT_LINE,
   input wire logic        O_SERIAL_OUT_LINE_OE,
   input wire logic        O_DAC_STROBE,
   input wire logic [15:0] O_CODEC_CONFIGURATION
);
   default clocking cb @(posedge I_CLK);
   endclocking
   // A deselect parks the divider, so timing checks pause with it.
   default disable iff (!I_RSTN || !I_CHIP_SEL);
   sequence s_hi; O_SCLK [*2] ##1 !O_SCLK; endsequence
   sequence s_lo; !O_SCLK [*3] ##1 O_SCLK; endsequence
   sequence s_fs; O_OUT_FRAME_SYNC [*5] ##1 !O_OUT_FRAME_SYNC; endsequence
   sequence s_ld; !O_SCLK && $past(O_SCLK); endsequence
   AST_SCK_HI: assert property ($rose(O_SCLK) |-> s_hi) else $error("sclk high");
   AST_SCK_LO: assert property ($fell(O_SCLK) |-> s_lo) else $error("sclk low");
   AST_FS_LEN: assert property ($rose(O_OUT_FRAME_SYNC) |-> s_fs) else $error("fs len");
   AST_FS_EDGE: assert property ($rose(O_OUT_FRAME_SYNC) |-> $rose(O_SCLK))
      else $error("fs edge");
   AST_FS_PWR: assert property ($rose(O_OUT_FRAME_SYNC) |-> &O_CODEC_CONFIGURATION[5:4])
      else $error("fs unpowered");
   AST_DO_EDGE: assert property ($changed(O_SERIAL_OUT_LINE) |-> $rose(O_SCLK))
      else $error("data edge");
   AST_CFG_TOP: assert property ($changed(O_CODEC_CONFIGURATION) |-> !O_CODEC_CONFIGURATION[15])
      else $error("cfg top bit");
   AST_CFG_LD: assert property ($changed(O_CODEC_CONFIGURATION) |-> s_ld)
      else $error("cfg load time");
   AST_STB: assert property (O_DAC_STROBE |-> s_ld ##1 !O_DAC_STROBE)
      else $error("strobe");
   AST_OE: assert property (disable iff (!I_RSTN) {O_SCLK_OE, O_OUT_FRAME_SYNC_OE,
      O_SERIAL_OUT_LINE_OE} == {3{I_CHIP_SEL}}) else $error("enables");
   AST_DESEL: assert property (disable iff (!I_RSTN) !I_CHIP_SEL [*2] |->
      !O_SCLK && !O_OUT_FRAME_SYNC) else $error("deselect");
endmodule
bind vsp_port vsp_port_sva vsp_port_sva_i
(
   .I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_CHIP_SEL(I_CHIP_SEL), .O_SCLK(O_SCLK),
   .O_SCLK_OE(O_SCLK_OE), .O_OUT_FRAME_SYNC(O_OUT_FRAME_SYNC),
   .O_OUT_FRAME_SYNC_OE(O_OUT_FRAME_SYNC_OE), .O_SERIAL_OUT_LINE(O_SERIAL_OUT_LINE),
   .O_SERIAL_OUT_LINE_OE(O_SERIAL_OUT_LINE_OE), .O_DAC_STROBE(O_DAC_STROBE),
   .O_CODEC_CONFIGURATION(O_CODEC_CONFIGURATION)
);

// [test/vsp_tb.sv]
/* Testbench for the serial port with the host model on the serial side.
   Assumes the checker is bound in through its own file. */
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin num_errors++; \
   $display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end
module testbench;
   logic        clk, rst_n, cs, ifs, sin, wts, sck, sck_oe, ofs, ofs_oe, sout, sout_oe;
   logic        stb, pre, src, ohp, ihp, apw, dpw;
   logic [2:0]  gain;
   logic [15:0] adc, dac, cfg;
   int          num_errors = 0;
   int          total_checks = 0;
   vsp_port vsp_port_i
   (
      .I_CLK(clk), .I_RSTN(rst_n), .I_CHIP_SEL(cs), .I_IN_FRAME_SYNC(ifs),
      .I_SERIAL_IN_LINE(sin), .I_WORD_TYPE_SELECT(wts), .O_SCLK(sck), .O_SCLK_OE(sck_oe),
      .O_OUT_FRAME_SYNC(ofs), .O_OUT_FRAME_SYNC_OE(ofs_oe), .O_SERIAL_OUT_LINE(sout),
      .O_SERIAL_OUT_LINE_OE(sout_oe), .I_ADC_SAMPLE(adc), .O_DAC_SAMPLE(dac),
      .O_DAC_STROBE(stb), .O_PREAMP_INSERT(pre), .O_INPUT_SOURCE_SEL(src),
      .O_OUT_HPF_BYPASS(ohp), .O_IN_HPF_BYPASS(ihp), .O_ANALOG_POWER_ON(apw),
      .O_DIGITAL_POWER_ON(dpw), .O_OUTPUT_GAIN_CODE(gain), .O_CODEC_CONFIGURATION(cfg)
   );
   vsp_host vsp_host_i
   (
      .I_CLK(clk), .i_sclk(sck), .i_ofs(ofs), .i_sout(sout), .o_ifs(ifs), .o_sin(sin),
      .o_wts(wts), .o_rx(), .o_nrx(), .o_tmo()
   );
   always #5 clk = ~clk;
   task automatic stop_test(input int tmo);
      num_errors += tmo + vsp_host_i.o_tmo;
      if (num_errors == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Waits for the output sync, or for a collected word beyond count n.
   task automatic wt(input int lim, input bit fs, input int n, output int c);
      for (c = 1; c <= lim && (fs ? ofs !== 1'b1 : vsp_host_i.o_nrx == n); c++)
         @(negedge clk);
      if (c > lim)
         stop_test(1);
   endtask
   task automatic wr(input logic [15:0] w);
      vsp_host_i.send(w, 1'b0, 1'b0);
      `CHK(cfg, w)
   endtask
   task automatic t_reset();
      rst_n = 1'b0;
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      `CHK({cfg, ofs}, 17'h00000)
   endtask
   task automatic t_fields();
      int g;
      for (g = 0; g < 16; g++)
      begin
         wr({6'h00, g[2:0], 3'h0, g[3:0]});
         `CHK(gain, g[2:0])
         `CHK({ihp, ohp, src, pre}, g[3:0])
      end
   endtask
   task automatic t_power();
      int c;
      int n;
      for (c = 1; c < 3; c++)
      begin
         n = vsp_host_i.o_nrx;
         wr({10'h000, c[1:0], 4'h0});
         repeat (2000) @(negedge clk);
         `CHK(vsp_host_i.o_nrx, n)
      end
      wr(16'h0030);
      `CHK({dpw, apw}, 2'h3)
      wt(5 * (vsp_pkg::STARTUP_SCLKS + 4), 1'b1, 0, c);
      `CHK(c > 5 * (vsp_pkg::STARTUP_SCLKS - 1), 1'b1)
      repeat (5) @(negedge clk);
      wt(2000, 1'b1, 0, c);
      `CHK(c + 4, 5 * vsp_pkg::FRAME_SCLKS)
      wt(200, 1'b0, vsp_host_i.o_nrx, c);
      `CHK(vsp_host_i.o_rx, adc)
   endtask
   task automatic t_samp();
      vsp_host_i.send(16'hC35A, 1'b1, 1'b1);
      `CHK({dac, cfg}, 32'hC35A0030)
      vsp_host_i.send(16'h0031, 1'b0, 1'b1);
      `CHK(cfg, 16'h0031)
   endtask
   task automatic t_read();
      int c;
      int n;
      wt(2000, 1'b1, 0, c);
      wt(200, 1'b0, vsp_host_i.o_nrx, c);
      vsp_host_i.send(16'h8000, 1'b0, 1'b0);
      `CHK(cfg, 16'h0031)
      n = vsp_host_i.o_nrx;
      vsp_host_i.send(16'hC000, 1'b0, 1'b0);
      wt(4000, 1'b0, n, c);
      `CHK(vsp_host_i.o_rx, 16'h0031)
      wt(4000, 1'b0, n + 1, c);
      `CHK(vsp_host_i.o_rx, adc)
   endtask
   task automatic t_desel();
      cs = 1'b0;
      repeat (8) @(negedge clk);
      `CHK({sck_oe, ofs_oe, sout_oe, sck, ofs}, 5'h00)
      cs = 1'b1;
      `CHK(cfg, 16'h0031)
   endtask
   initial
   begin
      {clk, cs} = 2'b01;
      adc = 16'hA5C3;
      t_reset();
      t_fields();
      t_power();
      t_samp();
      t_read();
      t_desel();
      t_reset();
      stop_test(0);
   end
endmodule
